// ### inc/sar_adc_control_defines.vh
/*
  Register offsets, field positions, reset values and timing counts
  of the converter control block.
  Assumes an APB slave with byte addresses on word boundaries.
*/
`ifndef SAR_ADC_CONTROL_DEFINES_VH
`define SAR_ADC_CONTROL_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFF_CONV_CTRL 8'h00
`define OFF_RESULT_HIGH 8'h04
`define OFF_RESULT_LOW 8'h08
`define OFF_PIN_CLK_SEL 8'h0C
`define OFF_CORE_IRQ 8'h10
`define OFF_PERIPH_IE 8'h14
`define OFF_PERIPH_IF 8'h18

// ==========================================================
// Converter control fields
`define BIT_JUSTIFY 7
`define BIT_POS_REF 6
`define CHAN_MSB 4
`define CHAN_LSB 2
`define BIT_GO 1
`define BIT_ON 0

// ==========================================================
// Analog select and clock select fields
`define CLKSEL_MSB 6
`define CLKSEL_LSB 4
`define PIN_SEL_MSB 3
`define PIN_SEL_LSB 0

// ==========================================================
// Interrupt fields
`define BIT_GLOBAL_IRQ 7
`define BIT_PERIPH_IRQ 6
`define BIT_CONV_DONE 6

// ==========================================================
// Reset values
`define RST_CONV_CTRL 8'h00
`define RST_PIN_CLK_SEL 8'h0F
`define RST_IRQ 8'h00

// ==========================================================
// Timing
`define RESULT_BITS 10
`define ABORT_HOLD_PERIODS 2'd2
`define RC_CLOCK_SEL 2'b11

`endif

// ### rtl/bit_period_gen.v
/*
  Bit period strobe generator: free-running divider on the system
  clock, or edges of the internal RC clock.
  Assumes the RC clock is asynchronous to the system clock.
*/
`include "sar_adc_control_defines.vh"

module bit_period_gen (
  input wire clk,
  input wire rst_n,
  input wire [2:0] clock_select,
  input wire rc_clock,
  output reg tick
);

  reg [5:0] divider;
  reg rc_meta;
  reg rc_sync;
  reg rc_last;
  reg [5:0] mask;

  // ==========================================================
  // Division mask per select code
  always @*
  begin
    case (clock_select)
      3'b000: mask = 6'h01;
      3'b100: mask = 6'h03;
      3'b001: mask = 6'h07;
      3'b101: mask = 6'h0F;
      3'b010: mask = 6'h1F;
      3'b110: mask = 6'h3F;
      default: mask = 6'h00;
    endcase
  end

  // ==========================================================
  // Divider and RC edge detect
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divider <= 6'h00;
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_last <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      divider <= divider + 6'h01;
      rc_meta <= rc_clock;
      rc_sync <= rc_meta;
      rc_last <= rc_sync;
      if (clock_select[1:0] == `RC_CLOCK_SEL)
        tick <= rc_sync & ~rc_last;
      else
        tick <= ((divider & mask) == mask);
    end
  end

endmodule

// ### rtl/sar_adc_control.v
/*
  Control of a 10-bit successive approximation converter with APB
  registers, clock selection, completion flag and wake logic.
  Assumes an APB master, an analog comparator input from a pin and
  a sleep indication on the system clock.
*/
`include "sar_adc_control_defines.vh"

module sar_adc_control (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire COMP_IN,
  input wire RC_CLK_IN,
  input wire SLEEP_MODE,
  output wire [2:0] CHANNEL_SEL,
  output wire POS_REF_EXT,
  output wire [3:0] ANALOG_SELECT,
  output wire ADC_ENABLE,
  output wire SAMPLE_HOLD,
  output wire [9:0] DAC_CODE,
  output wire ADC_IRQ,
  output wire WAKE,
  output wire IRQ_VECTOR
);

  reg justify;
  reg pos_ref;
  reg [2:0] channel;
  reg go;
  reg adc_on;
  reg [2:0] clock_select;
  reg [3:0] analog_sel;
  reg global_irq_en;
  reg periph_irq_en;
  reg irq_enable;
  reg done_flag;
  reg [9:0] result;
  reg [1:0] holdoff;
  reg running;
  reg comp_meta;
  reg comp_sync;
  reg pready;
  reg pslverr;
  reg [31:0] prdata;
  reg irq;
  reg wake;
  reg vector;
  reg hold;
  reg [31:0] next_prdata;
  reg next_hit;

  wire tick;
  wire seq_busy;
  wire seq_sampling;
  wire seq_done;
  wire [9:0] seq_trial;
  wire [9:0] seq_result;
  wire wr_now;
  wire rc_sel;
  wire abort;
  wire start;

  // ==========================================================
  // Address match
  function is_addr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  // ==========================================================
  // Justified result byte
  function [7:0] result_byte;
    input [9:0] r;
    input right;
    input high;
    begin
      if (right)
        result_byte = high ? {6'b00_0000, r[9:8]} : r[7:0];
      else
        result_byte = high ? r[9:2] : {r[1:0], 6'b00_0000};
    end
  endfunction

  assign wr_now = PSEL & PENABLE & PWRITE & pready;
  assign rc_sel = (clock_select[1:0] == `RC_CLOCK_SEL);
  assign abort = running & (~go | ~adc_on | (SLEEP_MODE & ~rc_sel));
  assign start = go & adc_on & ~running & (holdoff == 2'd0);

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign CHANNEL_SEL = channel;
  assign POS_REF_EXT = pos_ref;
  assign ANALOG_SELECT = analog_sel;
  assign ADC_ENABLE = adc_on;
  assign SAMPLE_HOLD = hold;
  assign DAC_CODE = seq_trial;
  assign ADC_IRQ = irq;
  assign WAKE = wake;
  assign IRQ_VECTOR = vector;

  // ==========================================================
  // Conversion clock and sequencer
  bit_period_gen u_bit_period (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .clock_select(clock_select),
    .rc_clock(RC_CLK_IN),
    .tick(tick)
  );

  sar_sequencer u_sequencer (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .start(start),
    .abort(abort),
    .tick(tick),
    .comp(comp_sync),
    .busy(seq_busy),
    .sampling(seq_sampling),
    .done(seq_done),
    .trial(seq_trial),
    .result(seq_result)
  );

  // ==========================================================
  // Read mux
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_hit = 1'b1;
    if (is_addr(PADDR, `OFF_CONV_CTRL))
      next_prdata[7:0] = {justify, pos_ref, 1'b0, channel, go, adc_on};
    else if (is_addr(PADDR, `OFF_RESULT_HIGH))
      next_prdata[7:0] = result_byte(result, justify, 1'b1);
    else if (is_addr(PADDR, `OFF_RESULT_LOW))
      next_prdata[7:0] = result_byte(result, justify, 1'b0);
    else if (is_addr(PADDR, `OFF_PIN_CLK_SEL))
      next_prdata[7:0] = {1'b0, clock_select, analog_sel};
    else if (is_addr(PADDR, `OFF_CORE_IRQ))
      next_prdata[7:0] = {global_irq_en, periph_irq_en, 6'b00_0000};
    else if (is_addr(PADDR, `OFF_PERIPH_IE))
      next_prdata[`BIT_CONV_DONE] = irq_enable;
    else if (is_addr(PADDR, `OFF_PERIPH_IF))
      next_prdata[`BIT_CONV_DONE] = done_flag;
    else
      next_hit = 1'b0;
  end

  // ==========================================================
  // APB handshake, one wait state
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= PSEL & PENABLE & ~pready;
      if (PSEL && PENABLE && !pready)
      begin
        pslverr <= ~next_hit;
        prdata <= PWRITE ? 32'h0000_0000 : next_prdata;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Control registers
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      justify <= 1'b0;
      pos_ref <= 1'b0;
      channel <= 3'b000;
      go <= 1'b0;
      adc_on <= 1'b0;
      clock_select <= 3'b000;
      analog_sel <= 4'hF;
      global_irq_en <= 1'b0;
      periph_irq_en <= 1'b0;
      irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_now && is_addr(PADDR, `OFF_CONV_CTRL))
      begin
        justify <= PWDATA[`BIT_JUSTIFY];
        pos_ref <= PWDATA[`BIT_POS_REF];
        channel <= PWDATA[`CHAN_MSB:`CHAN_LSB];
        go <= PWDATA[`BIT_GO];
        adc_on <= PWDATA[`BIT_ON];
      end
      if (seq_done || (running && SLEEP_MODE && !rc_sel))
        go <= 1'b0;
      if (wr_now && is_addr(PADDR, `OFF_PIN_CLK_SEL))
      begin
        clock_select <= PWDATA[`CLKSEL_MSB:`CLKSEL_LSB];
        analog_sel <= PWDATA[`PIN_SEL_MSB:`PIN_SEL_LSB];
      end
      if (wr_now && is_addr(PADDR, `OFF_CORE_IRQ))
      begin
        global_irq_en <= PWDATA[`BIT_GLOBAL_IRQ];
        periph_irq_en <= PWDATA[`BIT_PERIPH_IRQ];
      end
      if (wr_now && is_addr(PADDR, `OFF_PERIPH_IE))
        irq_enable <= PWDATA[`BIT_CONV_DONE];
    end
  end

  // ==========================================================
  // Conversion state, result and flag
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      running <= 1'b0;
      holdoff <= 2'd0;
      hold <= 1'b0;
      result <= 10'h000;
      done_flag <= 1'b0;
    end
    else
    begin
      comp_meta <= COMP_IN;
      comp_sync <= comp_meta;
      hold <= seq_busy & ~seq_sampling;
      if (start)
        running <= 1'b1;
      else if (seq_done || abort)
        running <= 1'b0;
      if (abort)
        holdoff <= `ABORT_HOLD_PERIODS;
      else if (tick && holdoff != 2'd0)
        holdoff <= holdoff - 2'd1;
      if (seq_done && running)
        result <= seq_result;
      // Software may write the flag; a completion in the same cycle wins
      if (wr_now && is_addr(PADDR, `OFF_PERIPH_IF))
        done_flag <= PWDATA[`BIT_CONV_DONE];
      if (seq_done)
        done_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Interrupt, wake and vector requests
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      irq <= 1'b0;
      wake <= 1'b0;
      vector <= 1'b0;
    end
    else
    begin
      irq <= done_flag & irq_enable;
      wake <= done_flag & irq_enable & SLEEP_MODE;
      vector <= done_flag & irq_enable & periph_irq_en & global_irq_en & ~SLEEP_MODE;
    end
  end

endmodule

// ### rtl/sar_sequencer.v
/*
  Successive approximation sequencer: one setup period, then one
  bit period per resolved bit, MSB first.
  Assumes a synchronised comparator level, high when input >= DAC.
*/
`include "sar_adc_control_defines.vh"

module sar_sequencer (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire abort,
  input wire tick,
  input wire comp,
  output reg busy,
  output reg sampling,
  output reg done,
  output reg [`RESULT_BITS-1:0] trial,
  output reg [`RESULT_BITS-1:0] result
);

  reg [`RESULT_BITS-1:0] mask;
  wire [`RESULT_BITS-1:0] decided;

  assign decided = comp ? trial : (trial & ~mask);

  // ==========================================================
  // Bit resolution
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      sampling <= 1'b0;
      done <= 1'b0;
      mask <= {`RESULT_BITS{1'b0}};
      trial <= {`RESULT_BITS{1'b0}};
      result <= {`RESULT_BITS{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy <= 1'b0;
        sampling <= 1'b0;
        mask <= {`RESULT_BITS{1'b0}};
      end
      else if (start)
      begin
        busy <= 1'b1;
        sampling <= 1'b1;
        mask <= {`RESULT_BITS{1'b0}};
        trial <= {`RESULT_BITS{1'b0}};
      end
      else if (busy && tick)
      begin
        if (sampling)
        begin
          sampling <= 1'b0;
          mask <= {1'b1, {(`RESULT_BITS-1){1'b0}}};
          trial <= {1'b1, {(`RESULT_BITS-1){1'b0}}};
        end
        else if (mask[0])
        begin
          result <= decided;
          trial <= decided;
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          trial <= decided | (mask >> 1);
          mask <= mask >> 1;
        end
      end
    end
  end

endmodule

// ### testbench/analog_source_model.sv
/* Analog inputs and comparator of the converter.
   Assumes the trial code arrives on dac_code. */
module analog_source_model (
  input logic [2:0] channel,
  input logic [9:0] dac_code,
  output logic comp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] level;
  // ====
  // Level of the routed input
  assign level = {channel, channel, 4'h9};
  assign comp_out = (level >= dac_code);
endmodule

// ### testbench/sar_adc_control_properties.sv
/* Port checker of sar_adc_control.
   Assumes a bind to the top module. */
module sar_adc_control_properties (
  input logic CLK_SYS,
  input logic RESET_N,
  input logic PSEL,
  input logic PENABLE,
  input logic [31:0] PRDATA,
  input logic PREADY,
  input logic PSLVERR,
  input logic SLEEP_MODE,
  input logic SAMPLE_HOLD,
  input logic [9:0] DAC_CODE,
  input logic ADC_IRQ,
  input logic WAKE,
  input logic IRQ_VECTOR
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Bus and converter relations
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  a_bus_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("bus answer not after one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
    else $error("error without ready or with data");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data outside answer");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_dac_first: assert property ($rose(SAMPLE_HOLD) |-> DAC_CODE == 10'h200)
    else $error("first trial code not midscale");
  a_hold_bound: assert property ($rose(SAMPLE_HOLD) |-> SAMPLE_HOLD[*2] ##[1:1000] !SAMPLE_HOLD)
    else $error("hold phase length wrong");
  a_wake_exact: assert property (WAKE == (ADC_IRQ && $past(SLEEP_MODE)))
    else $error("wake not irq during sleep");
  a_vector_awake: assert property (IRQ_VECTOR |-> ADC_IRQ && !$past(SLEEP_MODE))
    else $error("vector while asleep or no irq");
endmodule

bind sar_adc_control sar_adc_control_properties i_sar_adc_control_properties (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_MODE(SLEEP_MODE),
  .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE), .ADC_IRQ(ADC_IRQ), .WAKE(WAKE),
  .IRQ_VECTOR(IRQ_VECTOR));

// ### testbench/testbench.sv
/* Self-checking bench of sar_adc_control.
   Assumes the analog source model beside it. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, rc_clk, sleep, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, comp, pos_ref, adc_en, sh, irq, wake, vec;
  wire [2:0] chan;
  wire [3:0] ana;
  wire [9:0] dac;
  int err_total = 0;
  int total_checks = 0;
  logic [2:0] cs_tab [7] = '{3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  sar_adc_control i_sar_adc_control (.CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COMP_IN(comp),
    .RC_CLK_IN(rc_clk), .SLEEP_MODE(sleep), .CHANNEL_SEL(chan), .POS_REF_EXT(pos_ref),
    .ANALOG_SELECT(ana), .ADC_ENABLE(adc_en), .SAMPLE_HOLD(sh), .DAC_CODE(dac),
    .ADC_IRQ(irq), .WAKE(wake), .IRQ_VECTOR(vec));
  analog_source_model i_analog_source_model (.channel(chan), .dac_code(dac),
    .comp_out(comp));
  // ====
  // Shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk(pready, 1);
    r = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task conv(input logic [2:0] cs, input logic [2:0] ch, input logic j);
    logic [9:0] r;
    time t0;
    int dur, dv;
    r = {ch, ch, 4'h9};
    if (cs[1:0] == 2'h3) sleep <= 1'b1;
    apb(1, 8'h0C, {25'h0, cs, 4'hF}, rd);
    apb(1, 8'h00, {24'h0, j, ch[1], 1'b0, ch, 2'h1}, rd);
    repeat (20) @(posedge clk);
    t0 = $time;
    apb(1, 8'h00, {24'h0, j, ch[1], 1'b0, ch, 2'h3}, rd);
    chk(chan, ch);
    chk(pos_ref, ch[1]);
    chk(adc_en, 1);
    do apb(0, 8'h00, 0, rd); while (rd[1] === 1'b1 && $time - t0 < 40000);
    dur = ($time - t0) / 20;
    dv = 2 << {cs[1:0], cs[2]};
    if (cs[1:0] != 2'h3) chk(dur >= 10 * dv && dur <= 11 * dv + 16, 1);
    else chk(dur >= 64 && dur <= 92, 1);
    apb(0, 8'h18, 0, rd);
    chk(rd, 32'h0000_0040);
    apb(0, 8'h04, 0, rd);
    chk(rd, j ? {30'h0, r[9:8]} : {24'h0, r[9:2]});
    apb(0, 8'h08, 0, rd);
    chk(rd, j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h0});
  endtask
  // ====
  // Scenarios
  task t_regs;
    apb(0, 8'h00, 0, rd);
    chk(rd, 0);
    apb(0, 8'h0C, 0, rd);
    chk(rd, 32'h0000_000F);
    chk(ana, 4'hF);
    apb(1, 8'h04, 32'h0000_00FF, rd);
    apb(0, 8'h04, 0, rd);
    chk(rd, 0);
    apb(0, 8'h1C, 0, rd);
    chk({rd[30:0], serr}, 1);
    $display("done regs");
  endtask
  task t_convert;
    for (int i = 0; i < 7; i++) conv(cs_tab[i], i[2:0], i[0]);
    sleep <= 0;
    repeat (50) @(posedge clk);
    apb(0, 8'h18, 0, rd);
    chk(rd, 32'h0000_0040);
    $display("done convert");
  endtask
  task t_abort;
    logic [31:0] ph, pl;
    apb(1, 8'h18, 0, rd);
    apb(0, 8'h04, 0, ph);
    apb(0, 8'h08, 0, pl);
    apb(1, 8'h0C, 32'h0000_006F, rd);
    apb(1, 8'h00, 32'h0000_0007, rd);
    repeat (100) @(posedge clk);
    apb(1, 8'h00, 32'h0000_0005, rd);
    apb(0, 8'h18, 0, rd);
    chk(rd, 0);
    apb(0, 8'h04, 0, rd);
    chk(rd, ph);
    apb(0, 8'h08, 0, rd);
    chk(rd, pl);
    conv(3'h1, 3'h1, 1'b1);
    $display("done abort");
  endtask
  task t_fast;
    time t0;
    int dur;
    apb(1, 8'h18, 0, rd);
    apb(1, 8'h0C, 32'h0000_000F, rd);
    apb(1, 8'h00, 32'h0000_0001, rd);
    repeat (20) @(posedge clk);
    t0 = $time;
    apb(1, 8'h00, 32'h0000_0003, rd);
    do apb(0, 8'h00, 0, rd); while (rd[1] === 1'b1 && $time - t0 < 40000);
    dur = ($time - t0) / 20;
    // Two-cycle bit period is below the comparator path minimum: timing only
    chk(dur >= 20 && dur <= 38, 1);
    apb(0, 8'h18, 0, rd);
    chk(rd, 32'h0000_0040);
    // Sleep with a divided clock aborts the conversion
    apb(1, 8'h18, 0, rd);
    apb(1, 8'h0C, 32'h0000_006F, rd);
    apb(1, 8'h00, 32'h0000_0003, rd);
    repeat (20) @(posedge clk);
    sleep <= 1;
    repeat (4) @(posedge clk);
    sleep <= 0;
    apb(0, 8'h00, 0, rd);
    chk(rd, 32'h0000_0001);
    apb(0, 8'h18, 0, rd);
    chk(rd, 0);
    $display("done fast and sleep abort");
  endtask
  task t_irq;
    apb(1, 8'h18, 0, rd);
    apb(1, 8'h14, 32'h0000_0040, rd);
    apb(1, 8'h10, 32'h0000_00C0, rd);
    conv(3'h4, 3'h4, 1'b0);
    chk({irq, vec, wake}, 3'h6);
    sleep <= 1;
    apb(1, 8'h18, 0, rd);
    @(posedge clk);
    chk(irq, 0);
    conv(3'h3, 3'h5, 1'b1);
    repeat (2) @(posedge clk);
    chk({irq, vec, wake}, 3'h5);
    sleep <= 0;
    apb(1, 8'h14, 0, rd);
    apb(1, 8'h18, 0, rd);
    conv(3'h5, 3'h2, 1'b0);
    chk(irq, 0);
    $display("done irq");
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // Clocks, reset and sequence
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    rc_clk = 0;
    forever #65 rc_clk = ~rc_clk;
  end
  initial
  begin
    {psel, penable, pwrite, sleep, serr, rst_n} = 0;
    paddr = 0;
    pwdata = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs;
    t_convert;
    t_abort;
    t_fast;
    t_irq;
    final_report;
  end
  initial
  begin
    #1_000_000;
    err_total++;
    final_report;
  end
endmodule
